// File: dpc_pkg.sv
// Purpose: shared constants for the dual event performance counters
// Assumes: model register indices are local numbering
// Notes: widths of the setup word and tally fixed by the register layout
package dpc_pkg;
	localparam int TALLY_W = 40;
	localparam int SETUP_W = 32;
	localparam int EVT_LANES = 16;
	localparam int NUM_COUNTERS = 2;
	// Model register indices
	localparam logic [1:0] REG_SETUP_0 = 2'h0;
	localparam logic [1:0] REG_SETUP_1 = 2'h1;
	localparam logic [1:0] REG_TALLY_0 = 2'h2;
	localparam logic [1:0] REG_TALLY_1 = 2'h3;
	// Setup field positions
	localparam int EVT_CODE_LO = 0;
	localparam int UNIT_QUAL_LO = 8;
	localparam int USER_LEVEL_BIT = 16;
	localparam int KERNEL_LEVEL_BIT = 17;
	localparam int EDGE_BIT = 18;
	localparam int PIN_INC_BIT = 19;
	localparam int IRQ_EN_BIT = 20;
	localparam int GLOBAL_EN_BIT = 22;
	localparam int FLIP_BIT = 23;
	localparam int THRESH_LO = 24;
	localparam int READ_PERMIT_BIT = 8;
	localparam logic [31:0] SETUP_RESET = 32'h0000_0000;
	localparam logic [39:0] TALLY_RESET = 40'h00_0000_0000;
	localparam logic [31:0] SETUP1_MASK = 32'hFFBF_FFFF;
	// Bus clock ratio used to stretch pin pulses
	localparam int BUS_RATIO_DEF = 4;
	typedef enum logic [1:0] {PIN_IDLE, PIN_HIGH, PIN_LOW} dpc_pin_state_t;
endpackage

// File: dpc_pin_pulser.sv
// Purpose: one bus-clock wide monitor pin pulse
// Assumes: busTick marks a bus clock boundary, one cycle wide
// Notes: requests arriving during a pulse are merged
`timescale 1ns/1ps
module dpc_pin_pulser
	import dpc_pkg::*;
(
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	// Control
	input wire logic busTick,
	input wire logic request,
	// Pin
	output logic monitorPin
);
	dpc_pin_state_t state;
	dpc_pin_state_t next_state;
	logic pending;
	logic next_pending;

	always_comb
	begin
		next_state = state;
		next_pending = pending | request;
		case (state)
			PIN_IDLE:
				if (busTick && (pending || request))
				begin
					next_state = PIN_HIGH;
					next_pending = 1'b0;
				end
			PIN_HIGH:
				if (busTick)
					next_state = PIN_LOW;
			PIN_LOW:
				if (busTick)
					next_state = PIN_IDLE;
			default:
				next_state = PIN_IDLE;
		endcase
	end

	always_ff @(posedge sys_clk)
	begin
		if (!rst_n)
		begin
			state <= PIN_IDLE;
			pending <= 1'b0;
			monitorPin <= 1'b0;
		end
		else
		begin
			state <= next_state;
			pending <= next_pending;
			monitorPin <= (next_state == PIN_HIGH);
		end
	end
endmodule // dpc_pin_pulser

// File: dpc_event_tally.sv
// Purpose: one 40-bit event tally with filtering and compare
// Assumes: eventCount is the events seen in the current cycle
// Notes: overflow is the carry out of the top bit
`timescale 1ns/1ps
module dpc_event_tally
	import dpc_pkg::*;
#(
	parameter int WIDTH = TALLY_W
)
(
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	// Setup
	input wire logic [SETUP_W-1:0] setup,
	input wire logic runEnable,
	input wire logic [1:0] privLevel,
	input wire logic [4:0] eventCount,
	// Software load
	input wire logic loadStrobe,
	input wire logic [31:0] loadData,
	// State
	output logic [WIDTH-1:0] tally,
	output logic incremented,
	output logic overflow
);
	logic prevQual;
	logic next_prevQual;
	logic [WIDTH-1:0] next_tally;
	logic next_incremented;
	logic next_overflow;
	logic privOk;
	logic compareOk;
	logic qual;
	logic [4:0] addAmount;
	logic [WIDTH:0] sum;
	logic [7:0] thresh;

	always_comb
	begin
		thresh = setup[THRESH_LO +: 8];
		privOk = (privLevel == 2'h0) ? setup[KERNEL_LEVEL_BIT] : setup[USER_LEVEL_BIT];
		// Threshold wider than any per-cycle count never passes, or always passes when the flip bit is set
		compareOk = ({3'h0, eventCount} >= thresh) ^ setup[FLIP_BIT];
		qual = privOk && ((thresh != 8'h00) ? compareOk : (eventCount != 5'h00));
		addAmount = 5'h00;
		if (runEnable && qual)
		begin
			if (setup[EDGE_BIT])
				addAmount = prevQual ? 5'h00 : 5'h01;
			else if (thresh != 8'h00)
				addAmount = 5'h01;
			else
				addAmount = eventCount;
		end
		next_prevQual = qual;
		sum = {1'b0, tally} + {{(WIDTH-4){1'b0}}, addAmount};
		next_overflow = sum[WIDTH];
		next_incremented = (addAmount != 5'h00);
		next_tally = sum[WIDTH-1:0];
		if (loadStrobe)
		begin
			next_tally = {{(WIDTH-32){loadData[31]}}, loadData};
			next_overflow = 1'b0;
			next_incremented = 1'b0;
		end
	end

	always_ff @(posedge sys_clk)
	begin
		if (!rst_n)
		begin
			tally <= TALLY_RESET;
			prevQual <= 1'b0;
			incremented <= 1'b0;
			overflow <= 1'b0;
		end
		else
		begin
			tally <= next_tally;
			prevQual <= next_prevQual;
			incremented <= next_incremented;
			overflow <= next_overflow;
		end
	end
endmodule // dpc_event_tally

// File: dpc_perf_counters.sv
// Summary of operation
// - Two independent 40-bit event counters
// - Duration mode adds one per true clock
// - Bits 7:0 select event code
// - Bits 15:8 qualify the event
// - Bit 16 counts at levels 1-3
// - Bit 17 counts at level 0
// - Bit 18 counts rising transitions only
// - Bit 19 pin per increment, else overflow
// - Pin pulse lasts one bus clock
// - Bit 20 raises interrupt on overflow
// - Bit 22 of setup 0 enables both
// - Bit 23 inverts compare when threshold nonzero
// - Nonzero threshold adds one when compare met
// - Zero threshold adds full event count
// - Counter write sign-extends from bit 31
// - Registers level 0 only; read-permit bit gates
// - Start on enable write; zeroed setup stops
//
// Purpose: dual performance counter top with model register access
// Assumes: event sources supply per-cycle counts per code and qualifier
// Notes: register access is the model register read/write port
//        pin pulses are stretched to one bus clock of BUS_RATIO processor clocks
//        selection outputs follow a setup write at the same edge that stores it
`timescale 1ns/1ps
module dpc_perf_counters
	import dpc_pkg::*;
#(
	parameter int BUS_RATIO = BUS_RATIO_DEF
)
(
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	// Processor state
	input wire logic [1:0] privLevel,
	input wire logic userCounterReadPermit,
	// Event sources: per-cycle counts selected by the code and qualifier outputs
	input wire logic [4:0] eventCount0,
	input wire logic [4:0] eventCount1,
	// Model register port
	input wire logic modelRegisterWrite,
	input wire logic modelRegisterRead,
	input wire logic [1:0] regIndex,
	input wire logic [39:0] writeData,
	output logic [39:0] readData,
	output logic readValid,
	output logic accessFault,
	// Counter read instruction
	input wire logic counterReadInstruction,
	input wire logic counterSelect,
	// Event selection to the event logic
	output logic [7:0] eventCode0,
	output logic [7:0] unitQualifier0,
	output logic [7:0] eventCode1,
	output logic [7:0] unitQualifier1,
	// Pins and interrupt
	output logic [1:0] monitorPin,
	output logic perfInterrupt
);
	logic [SETUP_W-1:0] eventSetup0;
	logic [SETUP_W-1:0] eventSetup1;
	logic [SETUP_W-1:0] next_eventSetup0;
	logic [SETUP_W-1:0] next_eventSetup1;
	logic [39:0] next_readData;
	logic next_readValid;
	logic next_accessFault;
	logic next_perfInterrupt;
	logic [7:0] busDiv;
	logic [7:0] next_busDiv;
	logic busTick;
	logic kernelMode;
	logic writeOk;
	logic [NUM_COUNTERS-1:0] loadStrobe;
	logic [NUM_COUNTERS-1:0] runEnable;
	logic [NUM_COUNTERS-1:0] incremented;
	logic [NUM_COUNTERS-1:0] overflow;
	logic [NUM_COUNTERS-1:0] pinRequest;
	logic [SETUP_W-1:0] setupOf [NUM_COUNTERS];
	logic [4:0] countOf [NUM_COUNTERS];
	logic [39:0] tallyOf [NUM_COUNTERS];

	// Next values of the selection outputs
	logic [7:0] next_eventCode0;
	logic [7:0] next_unitQualifier0;
	logic [7:0] next_eventCode1;
	logic [7:0] next_unitQualifier1;

	// Decoded setup writes and per-counter interrupt requests
	logic setupWrite0;
	logic setupWrite1;
	logic [NUM_COUNTERS-1:0] irqRequest;

	function automatic logic [7:0] fieldByte(input logic [SETUP_W-1:0] word, input int lo);
		fieldByte = word[lo +: 8];
	endfunction

	// Register view as software sees it; setup words read back zero-extended
	function automatic logic [39:0] regView(input logic [1:0] idx);
		if (isIndex(idx, REG_SETUP_0))
			regView = {8'h00, eventSetup0};
		else if (isIndex(idx, REG_SETUP_1))
			regView = {8'h00, eventSetup1};
		else if (isIndex(idx, REG_TALLY_0))
			regView = tallyOf[0];
		else
			regView = tallyOf[1];
	endfunction

	function automatic logic isIndex(input logic [1:0] idx, input logic [1:0] want);
		isIndex = (idx == want);
	endfunction

	// Only level 0 may touch the model registers
	assign kernelMode = (privLevel == 2'h0);
	assign writeOk = modelRegisterWrite && kernelMode;
	assign setupOf[0] = eventSetup0;
	assign setupOf[1] = eventSetup1;
	assign countOf[0] = eventCount0;
	assign countOf[1] = eventCount1;
	assign busTick = (busDiv == 8'h00);
	// Enable lives only in setup 0; an all-zero setup stops its own counter
	assign runEnable[0] = eventSetup0[GLOBAL_EN_BIT] && (eventSetup0 != SETUP_RESET);
	assign runEnable[1] = eventSetup0[GLOBAL_EN_BIT] && (eventSetup1 != SETUP_RESET);

	// One tally and one pin pulser per counter
	generate
		for (genvar i = 0; i < NUM_COUNTERS; i++)
		begin : g_ctr
			assign loadStrobe[i] = writeOk && isIndex(regIndex, i ? REG_TALLY_1 : REG_TALLY_0);
			// Per-increment or overflow source for the pin
			assign pinRequest[i] = setupOf[i][PIN_INC_BIT] ? incremented[i] : overflow[i];
			dpc_event_tally #(
				.WIDTH(TALLY_W)
			) u_tally (
				.sys_clk(sys_clk),
				.rst_n(rst_n),
				.setup(setupOf[i]),
				.runEnable(runEnable[i]),
				.privLevel(privLevel),
				.eventCount(countOf[i]),
				.loadStrobe(loadStrobe[i]),
				.loadData(writeData[31:0]),
				.tally(tallyOf[i]),
				.incremented(incremented[i]),
				.overflow(overflow[i])
			);
			dpc_pin_pulser u_pin (
				.sys_clk(sys_clk),
				.rst_n(rst_n),
				.busTick(busTick),
				.request(pinRequest[i]),
				.monitorPin(monitorPin[i])
			);
		end
	endgenerate

	// Bus clock divider; busTick marks the first processor clock of each bus clock
	always_comb
	begin
		next_busDiv = (busDiv == 8'(BUS_RATIO - 1)) ? 8'h00 : busDiv + 8'h01;
	end

	always_ff @(posedge sys_clk)
	begin
		if (!rst_n)
		begin
			busDiv <= 8'h00;
		end
		else
		begin
			busDiv <= next_busDiv;
		end
	end

	// Setup words; a refused write leaves both untouched
	assign setupWrite0 = writeOk && isIndex(regIndex, REG_SETUP_0);
	assign setupWrite1 = writeOk && isIndex(regIndex, REG_SETUP_1);

	always_comb
	begin
		next_eventSetup0 = eventSetup0;
		next_eventSetup1 = eventSetup1;
		if (setupWrite0)
			next_eventSetup0 = writeData[31:0];
		else if (setupWrite1)
			// Enable bit exists only in setup 0, so it is masked here
			next_eventSetup1 = writeData[31:0] & SETUP1_MASK;
	end

	always_ff @(posedge sys_clk)
	begin
		if (!rst_n)
		begin
			eventSetup0 <= SETUP_RESET;
			eventSetup1 <= SETUP_RESET;
		end
		else
		begin
			eventSetup0 <= next_eventSetup0;
			eventSetup1 <= next_eventSetup1;
		end
	end

	// Taken from the next setup word so the event logic sees a new selection at once
	always_comb
	begin
		next_eventCode0 = fieldByte(next_eventSetup0, EVT_CODE_LO);
		next_unitQualifier0 = fieldByte(next_eventSetup0, UNIT_QUAL_LO);
		next_eventCode1 = fieldByte(next_eventSetup1, EVT_CODE_LO);
		next_unitQualifier1 = fieldByte(next_eventSetup1, UNIT_QUAL_LO);
	end

	always_ff @(posedge sys_clk)
	begin
		if (!rst_n)
		begin
			eventCode0 <= 8'h00;
			unitQualifier0 <= 8'h00;
			eventCode1 <= 8'h00;
			unitQualifier1 <= 8'h00;
		end
		else
		begin
			eventCode0 <= next_eventCode0;
			unitQualifier0 <= next_unitQualifier0;
			eventCode1 <= next_eventCode1;
			unitQualifier1 <= next_unitQualifier1;
		end
	end

	// Read port; a model register access wins and a counter read in that cycle is dropped
	always_comb
	begin
		next_readData = 40'h00_0000_0000;
		next_readValid = 1'b0;
		next_accessFault = 1'b0;
		if (modelRegisterRead || modelRegisterWrite)
		begin
			if (!kernelMode)
				next_accessFault = 1'b1;
			else if (modelRegisterRead)
			begin
				next_readValid = 1'b1;
				next_readData = regView(regIndex);
			end
		end
		else if (counterReadInstruction)
		begin
			// Restricted to level 0 when the permit bit is clear
			if (!kernelMode && !userCounterReadPermit)
				next_accessFault = 1'b1;
			else
			begin
				next_readValid = 1'b1;
				next_readData = regView({1'b1, counterSelect});
			end
		end
	end

	always_ff @(posedge sys_clk)
	begin
		if (!rst_n)
		begin
			readData <= 40'h00_0000_0000;
			readValid <= 1'b0;
			accessFault <= 1'b0;
		end
		else
		begin
			readData <= next_readData;
			readValid <= next_readValid;
			accessFault <= next_accessFault;
		end
	end

	// Overflow request is a one-cycle pulse to the local interrupt controller
	always_comb
	begin
		for (int n = 0; n < NUM_COUNTERS; n++)
			irqRequest[n] = overflow[n] && setupOf[n][IRQ_EN_BIT];
		next_perfInterrupt = |irqRequest;
	end

	always_ff @(posedge sys_clk)
	begin
		if (!rst_n)
		begin
			perfInterrupt <= 1'b0;
		end
		else
		begin
			perfInterrupt <= next_perfInterrupt;
		end
	end
endmodule // dpc_perf_counters

// File: dpc_perf_counters_asserts.sv
// Purpose: port-level checks for the dual event performance counters
// Assumes: one clock domain, synchronous active-low reset
// Notes: pin width tracked by a small counter; only pin 0 is timed
`timescale 1ns/1ps
module dpc_perf_counters_asserts
	import dpc_pkg::*;
#(
	parameter int BUS_RATIO = BUS_RATIO_DEF
)
(
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	// Requests
	input wire logic [1:0] privLevel,
	input wire logic userCounterReadPermit,
	input wire logic modelRegisterWrite,
	input wire logic modelRegisterRead,
	input wire logic counterReadInstruction,
	input wire logic [1:0] regIndex,
	input wire logic [39:0] writeData,
	// Answers
	input wire logic [39:0] readData,
	input wire logic readValid,
	input wire logic accessFault,
	input wire logic [7:0] eventCode0,
	input wire logic [7:0] unitQualifier0,
	input wire logic [7:0] eventCode1,
	input wire logic [7:0] unitQualifier1,
	input wire logic [1:0] monitorPin
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	logic acc;
	logic [7:0] hiCnt;
	logic [7:0] next_hiCnt;
	assign acc = modelRegisterWrite || modelRegisterRead;
	always_comb next_hiCnt = (!rst_n || !monitorPin[0]) ? 8'h00 : hiCnt + 8'h01;
	always_ff @(posedge sys_clk) hiCnt <= next_hiCnt;
	property p_rdAnswer;
		modelRegisterRead && !modelRegisterWrite && privLevel == 2'h0 |=> readValid && !accessFault;
	endproperty
	a_rdAnswer: assert property (p_rdAnswer) else $error("read not answered");
	property p_refuse;
		acc && privLevel != 2'h0 |=> accessFault && !readValid;
	endproperty
	a_refuse: assert property (p_refuse) else $error("access above level 0 not refused");
	property p_permit;
		counterReadInstruction && !acc && (privLevel == 2'h0 || userCounterReadPermit) |=> readValid;
	endproperty
	a_permit: assert property (p_permit) else $error("counter read not answered");
	property p_deny;
		counterReadInstruction && !acc && privLevel != 2'h0 && !userCounterReadPermit |=> accessFault && !readValid;
	endproperty
	a_deny: assert property (p_deny) else $error("counter read not refused");
	property p_signExt;
		modelRegisterWrite && privLevel == 2'h0 && regIndex[1] ##1 modelRegisterRead && !modelRegisterWrite
			&& privLevel == 2'h0 && regIndex == $past(regIndex)
			|=> readData == {{8{$past(writeData[31], 2)}}, $past(writeData[31:0], 2)};
	endproperty
	a_signExt: assert property (p_signExt) else $error("tally load not sign extended");
	property p_setupBack;
		modelRegisterWrite && privLevel == 2'h0 && regIndex == REG_SETUP_1 ##1 modelRegisterRead
			&& !modelRegisterWrite && privLevel == 2'h0 && regIndex == REG_SETUP_1
			|=> readData == {8'h00, $past(writeData[31:0], 2) & SETUP1_MASK};
	endproperty
	a_setupBack: assert property (p_setupBack) else $error("second setup readback wrong");
	property p_code;
		modelRegisterWrite && privLevel == 2'h0 && regIndex == REG_SETUP_0 ##1 !modelRegisterWrite
			|=> eventCode0 == $past(writeData[7:0], 2) && unitQualifier0 == $past(writeData[15:8], 2);
	endproperty
	a_code: assert property (p_code) else $error("event selection outputs wrong");
	property p_code1;
		modelRegisterWrite && privLevel == 2'h0 && regIndex == REG_SETUP_1 ##1 !modelRegisterWrite
			|=> eventCode1 == $past(writeData[7:0], 2) && unitQualifier1 == $past(writeData[15:8], 2);
	endproperty
	a_code1: assert property (p_code1) else $error("second event selection outputs wrong");
	property p_pinWidth;
		$fell(monitorPin[0]) |-> hiCnt == 8'(BUS_RATIO);
	endproperty
	a_pinWidth: assert property (p_pinWidth) else $error("pin pulse not one bus clock");
endmodule // dpc_perf_counters_asserts

bind dpc_perf_counters dpc_perf_counters_asserts #(.BUS_RATIO(BUS_RATIO)) u_chk (.sys_clk, .rst_n, .privLevel,
	.userCounterReadPermit, .modelRegisterWrite, .modelRegisterRead, .counterReadInstruction, .regIndex,
	.writeData, .readData, .readValid, .accessFault, .eventCode0, .unitQualifier0, .eventCode1, .unitQualifier1,
	.monitorPin);

// File: dpc_perf_counters_tb.sv
// Purpose: self-checking bench for the dual event performance counters
// Assumes: bus ratio 2 keeps pin pulses short
// Notes: event sources and privilege are random while counting
`timescale 1ns/1ps
module dpc_perf_counters_tb
	import dpc_pkg::*;
;
	logic sys_clk, rst_n, userCounterReadPermit, modelRegisterWrite, modelRegisterRead, counterReadInstruction;
	logic counterSelect, readValid, accessFault, perfInterrupt, rv, af, pv0, pv1;
	logic [1:0] privLevel, regIndex, monitorPin, seen;
	logic [4:0] eventCount0, eventCount1;
	logic [39:0] writeData, readData, rdat, e0, e1;
	logic [7:0] eventCode0;
	int errTotal = 0, numChecks = 0;
	// Rows: plain, threshold, edge with ignored flip, global enable off, second setup zero
	logic [31:0] s0 [5] = '{32'h0043_0000, 32'h0242_0000, 32'h0047_0000, 32'h0003_0000, 32'h0043_C1A5};
	logic [31:0] s1 [5] = '{32'h0001_0000, 32'h0281_0000, 32'h0082_0000, 32'h0003_0000, 32'h0000_0000};
	dpc_perf_counters #(.BUS_RATIO(2)) DUT (.sys_clk, .rst_n, .privLevel, .userCounterReadPermit, .eventCount0,
		.eventCount1, .modelRegisterWrite, .modelRegisterRead, .regIndex, .writeData, .readData, .readValid,
		.accessFault, .counterReadInstruction, .counterSelect, .eventCode0, .unitQualifier0(), .eventCode1(),
		.unitQualifier1(), .monitorPin, .perfInterrupt);
	initial
	begin
		sys_clk = 1'b0;
		forever #4 sys_clk = ~sys_clk;
	end
	task automatic chk(input logic [39:0] e, g);
		numChecks++;
		if (g !== e)
		begin
			errTotal++;
			$display("ERROR t=%0t exp=%h got=%h", $time, e, g);
		end
	endtask
	task automatic complete_run();
		$display("checks=%0d errors=%0d", numChecks, errTotal);
		if (errTotal == 0 && numChecks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// Write together with read issues the read on the very next cycle
	task automatic xfer(input logic w, r, c, input logic [1:0] i, input logic [39:0] d);
		@(posedge sys_clk);
		modelRegisterWrite <= w;
		modelRegisterRead <= r && !w;
		counterReadInstruction <= c;
		regIndex <= i;
		counterSelect <= i[0];
		writeData <= d;
		if (w && r)
		begin
			@(posedge sys_clk);
			modelRegisterWrite <= 1'b0;
			modelRegisterRead <= 1'b1;
		end
		@(posedge sys_clk);
		modelRegisterWrite <= 1'b0;
		modelRegisterRead <= 1'b0;
		counterReadInstruction <= 1'b0;
		#1;
		rv = readValid;
		rdat = readData;
		af = accessFault;
	endtask
	function automatic logic [39:0] expR(input logic [1:0] i, input logic [39:0] d);
		expR = i[1] ? {{8{d[31]}}, d[31:0]} : {8'h00, d[31:0] & (i[0] ? SETUP1_MASK : 32'hFFFF_FFFF)};
	endfunction
	task automatic wr(input logic [1:0] i, input logic [39:0] d);
		xfer(1'b1, 1'b1, 1'b0, i, d);
		chk(expR(i, d), rdat);
		chk(40'h1, {39'h0, rv});
	endtask
	// Events added this cycle; pv holds the qualified condition of the last cycle
	function automatic logic [4:0] amt(input logic [31:0] s, input logic [4:0] c, input logic [1:0] p,
		input logic en, inout logic pv);
		logic q, hit;
		q = p == 2'h0 ? s[17] : s[16];
		hit = q && (s[31:24] == 8'h00 ? c != 5'h0 : ({3'h0, c} >= s[31:24]) != s[23]);
		amt = !en ? 5'h0 : s[18] ? 5'(hit && !pv) : s[31:24] == 8'h00 ? (q ? c : 5'h0) : 5'(hit);
		pv = hit;
	endfunction
	// Raise one event on either counter, then watch the pin and the interrupt
	task automatic kick(input logic [4:0] a, b, input int p);
		@(posedge sys_clk);
		eventCount0 <= a;
		eventCount1 <= b;
		@(posedge sys_clk);
		eventCount0 <= 5'h0;
		eventCount1 <= 5'h0;
		seen = 2'h0;
		repeat (12)
		begin
			@(posedge sys_clk);
			#1;
			seen |= {perfInterrupt, monitorPin[p]};
		end
	endtask
	initial
	begin
		{rst_n, privLevel, userCounterReadPermit, eventCount0, eventCount1} = '0;
		{modelRegisterWrite, modelRegisterRead, counterReadInstruction, counterSelect, regIndex, writeData} = '0;
		void'($urandom(32'h407A));
		repeat (16) @(posedge sys_clk);
		rst_n <= 1'b1;
		for (int k = 0; k < 6; k++)
			wr({1'b1, k[0]}, {8'($urandom), k == 0 ? 32'h7FFF_FFFF : k == 1 ? 32'h8000_0000 : 32'($urandom)});
		for (int r = 0; r < 5; r++)
		begin
			wr(REG_SETUP_1, {8'h00, s1[r]});
			wr(REG_TALLY_0, 40'h00_0000_0000);
			wr(REG_TALLY_1, 40'h00_0000_0000);
			wr(REG_SETUP_0, {8'h00, s0[r]});
			chk({32'h0, s0[r][7:0]}, {32'h0, eventCode0});
			{e0, e1, pv0, pv1} = '0;
			repeat (40)
			begin
				@(posedge sys_clk);
				privLevel <= 2'($urandom);
				eventCount0 <= 5'($urandom % 4);
				eventCount1 <= 5'($urandom % 4);
				#1;
				e0 += 40'(amt(s0[r], eventCount0, privLevel, s0[r][22], pv0));
				e1 += 40'(amt(s1[r], eventCount1, privLevel, s0[r][22] && s1[r] != 32'h0, pv1));
			end
			@(posedge sys_clk);
			{privLevel, eventCount0, eventCount1} <= '0;
			xfer(1'b1, 1'b0, 1'b0, REG_SETUP_0, 40'h0);
			xfer(1'b0, 1'b1, 1'b0, REG_TALLY_0, 40'h0);
			chk(e0, rdat);
			xfer(1'b0, 1'b1, 1'b0, REG_TALLY_1, 40'h0);
			chk(e1, rdat);
		end
		wr(REG_TALLY_0, 40'h00_FFFF_FFFF);
		wr(REG_SETUP_0, 40'h00_0053_0000);
		kick(5'h1, 5'h0, 0);
		chk(40'h3, {38'h0, seen});
		xfer(1'b0, 1'b1, 1'b0, REG_TALLY_0, 40'h0);
		chk(40'h0, rdat);
		wr(REG_SETUP_1, 40'h00_000B_0000);
		wr(REG_TALLY_1, 40'h00_1234_5678);
		kick(5'h0, 5'h1, 1);
		chk(40'h1, {38'h0, seen});
		@(posedge sys_clk);
		privLevel <= 2'h3;
		xfer(1'b1, 1'b0, 1'b0, REG_SETUP_0, 40'hFF_FFFF_FFFF);
		chk(40'h1, {39'h0, af});
		xfer(1'b0, 1'b0, 1'b1, REG_TALLY_1, 40'h0);
		chk(40'h1, {39'h0, af});
		@(posedge sys_clk);
		userCounterReadPermit <= 1'b1;
		xfer(1'b0, 1'b0, 1'b1, REG_TALLY_1, 40'h0);
		chk(40'h00_1234_5679, rdat);
		@(posedge sys_clk);
		privLevel <= 2'h0;
		xfer(1'b0, 1'b1, 1'b0, REG_SETUP_0, 40'h0);
		chk(40'h00_0053_0000, rdat);
		complete_run();
	end
	initial
	begin
		repeat (5000) @(posedge sys_clk);
		errTotal++;
		complete_run();
	end
endmodule // dpc_perf_counters_tb
